// >>> hdl/ccp_completion_host.sv
// Notes on behaviour
// - attribute bits: no snoop, relaxed, id order
// - byte count derived from request byte enables
// - at least one completion per non-posted request
// - split data: each completion own descriptor
// - dword mode: payload right after descriptor
// - payload padded to whole aligned dwords
// - valid held high through whole packet
// - last only on the final beat
// - port signals frozen while ready low
// - address mode: payload starts next beat
// - memory read lane from address, else zero
// - lower address bits 6:2 give dword start
// - discontinue aborts a payload completion
// - end early or continue; error stays sticky
// - discontinue only with valid, held until ready
// - UR/CA completion is an 8-dword packet
// - fourth dword copies enables and hint fields
// - error packet dwords packed in both modes
`timescale 1ns/1ps
`default_nettype none
`include "ccp_cfg.svh"

module ccp_completion_host #(
   parameter int DATA_W = 64,
   parameter int SB_W = 33,
   parameter int PAY_DEPTH = 64
) (
   input wire logic i_ref_clk,
   input wire logic i_reset_n,
   input wire ccp_pkg::ccp_apb_req_s i_apb,
   output logic o_pready,
   output logic [31:0] o_prdata,
   output logic o_pslverr,
   output logic [DATA_W-1:0] o_cc_data,
   output logic o_cc_valid,
   output logic o_cc_last,
   output logic [SB_W-1:0] o_cc_sideband,
   input wire logic i_cc_ready
);
   import ccp_pkg::*;

   // ==========================================================
   // geometry
   localparam int LANES = DATA_W / 32;
   localparam int LANE_W = (LANES > 1) ? $clog2(LANES) : 1;
   localparam int PAY_AW = $clog2(PAY_DEPTH);
   localparam ccp_pos_t HDR_ALIGNED = 12'(((3 + LANES - 1) / LANES) * LANES);
   localparam ccp_pos_t LANE_MASK = 12'(LANES - 1);

   // ==========================================================
   // register state
   logic [31:0] ctrl_q;
   ccp_req_info_s info_q;
   logic [31:0] desc_q [0:2];
   logic [31:0] req_q [0:3];
   logic [31:0] pay_mem [0:PAY_DEPTH-1];
   logic [PAY_AW-1:0] pay_idx_q;
   logic [9:0] disc_q;
   logic [15:0] sent_q;
   logic aborted_q;
   logic start_q;
   logic [31:0] prdata_q;
   logic pslverr_q;

   // stream state
   ccp_state_e state_q;
   logic [7:0] beat_q;
   logic valid_q;
   logic last_q;
   logic [DATA_W-1:0] data_q;
   logic [SB_W-1:0] sb_q;

   // ==========================================================
   // bus decode
   logic busy;
   logic apb_setup;
   logic apb_wr;
   logic beat_done;

   // every word from control up to byte count is mapped
   function automatic logic addr_hit(input logic [7:0] a);
      addr_hit = (a[1:0] == 2'b00) && (a <= `CCP_ADDR_LAST);
   endfunction : addr_hit

   assign busy = (state_q != CCP_IDLE) || start_q;
   assign apb_setup = i_apb.psel && !i_apb.penable;
   assign apb_wr = i_apb.psel && i_apb.penable && i_apb.pwrite && addr_hit(i_apb.paddr) && !busy;
   assign beat_done = valid_q && i_cc_ready;

   // ==========================================================
   // packet geometry from the programmed descriptor
   logic addr_mode;
   logic err_cpl;
   logic mem_read;
   logic has_data;
   logic [10:0] dword_count;
   logic [12:0] byte_count;
   ccp_pos_t pay_len;
   ccp_pos_t lane_off;
   ccp_pos_t start_pos;
   ccp_pos_t end_pos;
   logic [7:0] last_beat;
   logic disc_en;
   logic [7:0] next_beat;
   logic beat_disc;
   logic beat_last;
   logic [31:0] desc_w [0:2];
   logic [DATA_W-1:0] beat_data;

   assign addr_mode = ctrl_q[`CCP_CTRL_ADDR_MODE];
   assign err_cpl = ctrl_q[`CCP_CTRL_ERR_CPL];
   assign mem_read = ctrl_q[`CCP_CTRL_MEM_READ];
   assign has_data = ctrl_q[`CCP_CTRL_HAS_DATA];
   assign dword_count = desc_q[1][10:0];

   // byte count placed into the outgoing descriptor
   ccp_byte_count u_byte_count (
      .i_first_byte_enables(info_q.first_byte_enables),
      .i_last_byte_enables(info_q.last_byte_enables),
      .i_dword_count(dword_count),
      .o_byte_count(byte_count)
   );

   // payload start: after descriptor, or on a fresh beat at its address lane for memory reads, lane zero otherwise
   assign pay_len = (err_cpl || !has_data) ? 12'd0 : {1'b0, dword_count};
   assign lane_off = (addr_mode && mem_read) ? ({7'd0, desc_q[0][6:2]} & LANE_MASK) : 12'd0;
   assign start_pos = (addr_mode ? HDR_ALIGNED : `CCP_DESC_DW) + lane_off;
   assign end_pos = err_cpl ? `CCP_ERR_PKT_DW :
                    ((pay_len == 12'd0) ? `CCP_DESC_DW : start_pos + pay_len);
   assign last_beat = 8'((end_pos - 12'd1) >> LANE_W);

   // abort injection only applies to completions with payload
   assign disc_en = disc_q[`CCP_DISC_ENABLE] && has_data && !err_cpl;
   assign next_beat = (state_q == CCP_SEND) ? beat_q + 8'd1 : 8'd0;
   assign beat_disc = disc_en && (next_beat == disc_q[`CCP_DISC_BEAT_MSB:0]);
   assign beat_last = (next_beat == last_beat) || (beat_disc && disc_q[`CCP_DISC_EARLY_END]);

   // descriptor words with computed count, attributes and digest bit
   assign desc_w[0] = (desc_q[0] & ~`CCP_DESC_BC_MASK) | ({19'd0, byte_count} << `CCP_DESC_BC_LSB);
   assign desc_w[1] = desc_q[1];
   assign desc_w[2] = (desc_q[2] & ~`CCP_DESC2_ATTR_MASK)
                      | {ctrl_q[`CCP_CTRL_FORCE_ECRC], ctrl_q[`CCP_CTRL_ATTR_LSB+2:`CCP_CTRL_ATTR_LSB], 28'd0};

   // ==========================================================
   // one source selector per dword lane of the next beat
   for (genvar j = 0; j < LANES; j++) begin : g_lane
      ccp_pos_t pos;
      ccp_pos_t off;
      ccp_src_e src;
      logic [31:0] word;

      assign pos = ({4'd0, next_beat} << LANE_W) + 12'(j);

      ccp_dword_src u_src (
         .i_pos(pos),
         .i_start(start_pos),
         .i_end(end_pos),
         .i_err(err_cpl),
         .o_src(src),
         .o_off(off)
      );

      // lane word from descriptor, request copy or payload store
      always_comb begin
         case (src)
            CCP_SRC_DESC: word = desc_w[off[1:0]];
            CCP_SRC_INFO: word = {13'd0, info_q};
            CCP_SRC_REQ: word = req_q[off[1:0]];
            CCP_SRC_PAY: word = pay_mem[off[PAY_AW-1:0]];
            default: word = 32'h0000_0000;
         endcase
      end

      assign beat_data[j*32 +: 32] = word;
   end

   // ==========================================================
   // control, request and descriptor registers
   always_ff @(posedge i_ref_clk) begin
      if (!i_reset_n) begin
         ctrl_q <= `CCP_CTRL_RESET;
         info_q <= '0;
         disc_q <= 10'h000;
         for (int k = 0; k < 3; k++) begin
            desc_q[k] <= 32'h0000_0000;
         end
         for (int k = 0; k < 4; k++) begin
            req_q[k] <= 32'h0000_0000;
         end
      end else if (apb_wr) begin
         case (i_apb.paddr)
            `CCP_ADDR_CTRL: ctrl_q <= i_apb.pwdata & ~(32'h1 << `CCP_CTRL_START);
            `CCP_ADDR_REQ_INFO: info_q <= i_apb.pwdata[18:0];
            `CCP_ADDR_DESC0: desc_q[0] <= i_apb.pwdata;
            `CCP_ADDR_DESC1: desc_q[1] <= i_apb.pwdata;
            `CCP_ADDR_DESC2: desc_q[2] <= i_apb.pwdata;
            `CCP_ADDR_REQ0: req_q[0] <= i_apb.pwdata;
            `CCP_ADDR_REQ1: req_q[1] <= i_apb.pwdata;
            `CCP_ADDR_REQ2: req_q[2] <= i_apb.pwdata;
            `CCP_ADDR_REQ3: req_q[3] <= i_apb.pwdata;
            `CCP_ADDR_DISC: disc_q <= i_apb.pwdata[9:0];
            default: ;
         endcase
      end
   end

   // payload store, written word by word with auto increment
   always_ff @(posedge i_ref_clk) begin
      if (!i_reset_n) begin
         pay_idx_q <= '0;
      end else if (apb_wr && i_apb.paddr == `CCP_ADDR_PAY_IDX) begin
         pay_idx_q <= i_apb.pwdata[PAY_AW-1:0];
      end else if (apb_wr && i_apb.paddr == `CCP_ADDR_PAY_DATA) begin
         pay_idx_q <= pay_idx_q + 1'b1;
      end
   end

   // memory array has no reset, contents are software data
   always_ff @(posedge i_ref_clk) begin
      if (apb_wr && i_apb.paddr == `CCP_ADDR_PAY_DATA) begin
         pay_mem[pay_idx_q] <= i_apb.pwdata;
      end
   end

   // start pulse, launched one cycle later on updated settings
   always_ff @(posedge i_ref_clk) begin
      if (!i_reset_n) begin
         start_q <= 1'b0;
      end else begin
         start_q <= apb_wr && (i_apb.paddr == `CCP_ADDR_CTRL) && i_apb.pwdata[`CCP_CTRL_START];
      end
   end

   // ==========================================================
   // read data and error, captured in the setup phase
   always_ff @(posedge i_ref_clk) begin
      if (!i_reset_n) begin
         prdata_q <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else if (apb_setup) begin
         pslverr_q <= !addr_hit(i_apb.paddr);
         case (i_apb.paddr)
            `CCP_ADDR_CTRL: prdata_q <= ctrl_q;
            `CCP_ADDR_REQ_INFO: prdata_q <= {13'd0, info_q};
            `CCP_ADDR_DESC0: prdata_q <= desc_q[0];
            `CCP_ADDR_DESC1: prdata_q <= desc_q[1];
            `CCP_ADDR_DESC2: prdata_q <= desc_q[2];
            `CCP_ADDR_REQ0: prdata_q <= req_q[0];
            `CCP_ADDR_REQ1: prdata_q <= req_q[1];
            `CCP_ADDR_REQ2: prdata_q <= req_q[2];
            `CCP_ADDR_REQ3: prdata_q <= req_q[3];
            `CCP_ADDR_PAY_IDX: prdata_q <= 32'(pay_idx_q);
            `CCP_ADDR_PAY_DATA: prdata_q <= pay_mem[pay_idx_q];
            `CCP_ADDR_DISC: prdata_q <= {22'd0, disc_q};
            `CCP_ADDR_STATUS: prdata_q <= {sent_q, 14'd0, aborted_q, busy};
            `CCP_ADDR_BCOUNT: prdata_q <= {19'd0, byte_count};
            default: prdata_q <= 32'h0000_0000;
         endcase
      end
   end

   // ==========================================================
   // stream sequencer: one beat register, advanced on handshake
   always_ff @(posedge i_ref_clk) begin
      if (!i_reset_n) begin
         state_q <= CCP_IDLE;
         beat_q <= 8'h00;
         valid_q <= 1'b0;
         last_q <= 1'b0;
         data_q <= '0;
         sb_q <= '0;
      end else begin
         case (state_q)
            CCP_IDLE: begin
               if (start_q) begin
                  state_q <= CCP_SEND;
                  beat_q <= 8'h00;
                  valid_q <= 1'b1;
                  data_q <= beat_data;
                  last_q <= beat_last;
                  sb_q <= SB_W'(beat_disc) << `CCP_SB_DISCONTINUE;
               end
            end
            CCP_SEND: begin
               // nothing changes until the beat is taken
               if (beat_done) begin
                  if (last_q) begin
                     state_q <= CCP_IDLE;
                     valid_q <= 1'b0;
                     last_q <= 1'b0;
                     sb_q <= '0;
                  end else begin
                     beat_q <= next_beat;
                     valid_q <= 1'b1;
                     data_q <= beat_data;
                     last_q <= beat_last;
                     sb_q <= SB_W'(beat_disc) << `CCP_SB_DISCONTINUE;
                  end
               end
            end
            default: begin
               state_q <= CCP_IDLE;
               valid_q <= 1'b0;
               last_q <= 1'b0;
               sb_q <= '0;
            end
         endcase
      end
   end

   // completed packet counter and abort flag
   always_ff @(posedge i_ref_clk) begin
      if (!i_reset_n) begin
         sent_q <= 16'h0000;
         aborted_q <= 1'b0;
      end else begin
         if (beat_done && last_q) begin
            sent_q <= sent_q + 16'h0001;
         end
         if (beat_done && sb_q[`CCP_SB_DISCONTINUE]) begin
            aborted_q <= 1'b1;
         end else if (start_q) begin
            aborted_q <= 1'b0;
         end
      end
   end

   // ==========================================================
   // outputs
   assign o_pready = 1'b1;
   assign o_prdata = prdata_q;
   assign o_pslverr = pslverr_q;
   assign o_cc_data = data_q;
   assign o_cc_valid = valid_q;
   assign o_cc_last = last_q;
   assign o_cc_sideband = sb_q;

endmodule : ccp_completion_host

`default_nettype wire

// >>> hdl/ccp_cfg.svh
`ifndef CCP_CFG_SVH
`define CCP_CFG_SVH

// ==========================================================
// register map of the controller (byte addresses, APB)
`define CCP_ADDR_CTRL 8'h00
`define CCP_ADDR_REQ_INFO 8'h04
`define CCP_ADDR_DESC0 8'h08
`define CCP_ADDR_DESC1 8'h0c
`define CCP_ADDR_DESC2 8'h10
`define CCP_ADDR_REQ0 8'h14
`define CCP_ADDR_REQ1 8'h18
`define CCP_ADDR_REQ2 8'h1c
`define CCP_ADDR_REQ3 8'h20
`define CCP_ADDR_PAY_IDX 8'h24
`define CCP_ADDR_PAY_DATA 8'h28
`define CCP_ADDR_DISC 8'h2c
`define CCP_ADDR_STATUS 8'h30
`define CCP_ADDR_BCOUNT 8'h34
`define CCP_ADDR_LAST 8'h34

// ==========================================================
// control register fields
`define CCP_CTRL_START 0
`define CCP_CTRL_ADDR_MODE 1
`define CCP_CTRL_ERR_CPL 2
`define CCP_CTRL_FORCE_ECRC 3
`define CCP_CTRL_MEM_READ 4
`define CCP_CTRL_HAS_DATA 5
`define CCP_CTRL_ATTR_LSB 6
`define CCP_CTRL_RESET 32'h0000_0000

// discontinue register fields
`define CCP_DISC_BEAT_MSB 7
`define CCP_DISC_ENABLE 8
`define CCP_DISC_EARLY_END 9

// ==========================================================
// completion descriptor fields, positions inside each dword
`define CCP_DESC_BC_LSB 16
`define CCP_DESC_BC_MASK 32'h1fff_0000
`define CCP_DESC2_ATTR_MASK 32'hf000_0000
`define CCP_DESC_DW 12'd3
`define CCP_ERR_PKT_DW 12'd8
`define CCP_ERR_INFO_POS 12'd3
`define CCP_ERR_REQ_POS 12'd4

// sideband bit that aborts the packet
`define CCP_SB_DISCONTINUE 0

`endif

// >>> hdl/ccp_pkg.sv
package ccp_pkg;

   // ==========================================================
   // sequencer states, one-hot
   typedef enum logic [1:0] {
      CCP_IDLE = 2'b01,
      CCP_SEND = 2'b10
   } ccp_state_e;

   // source of one dword lane of a beat, one-hot
   typedef enum logic [4:0] {
      CCP_SRC_ZERO = 5'b00001,
      CCP_SRC_DESC = 5'b00010,
      CCP_SRC_INFO = 5'b00100,
      CCP_SRC_REQ = 5'b01000,
      CCP_SRC_PAY = 5'b10000
   } ccp_src_e;

   // APB request from the bus master
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } ccp_apb_req_s;

   // request information copied into the error completion
   typedef struct packed {
      logic [7:0] hint_steering_tag;
      logic [1:0] hint_type;
      logic hint_present;
      logic [3:0] last_byte_enables;
      logic [3:0] first_byte_enables;
   } ccp_req_info_s;

   typedef logic [11:0] ccp_pos_t;

endpackage : ccp_pkg

// >>> hdl/ccp_byte_count.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// byte count of a completion from the request byte enables
module ccp_byte_count (
   input wire logic [3:0] i_first_byte_enables,
   input wire logic [3:0] i_last_byte_enables,
   input wire logic [10:0] i_dword_count,
   output logic [12:0] o_byte_count
);

   // zero bytes below the lowest enabled lane
   function automatic logic [2:0] low_zeros(input logic [3:0] be);
      casez (be)
         4'b???1: low_zeros = 3'd0;
         4'b??10: low_zeros = 3'd1;
         4'b?100: low_zeros = 3'd2;
         4'b1000: low_zeros = 3'd3;
         default: low_zeros = 3'd0;
      endcase
   endfunction : low_zeros

   // zero bytes above the highest enabled lane
   function automatic logic [2:0] high_zeros(input logic [3:0] be);
      casez (be)
         4'b1???: high_zeros = 3'd0;
         4'b01??: high_zeros = 3'd1;
         4'b001?: high_zeros = 3'd2;
         4'b0001: high_zeros = 3'd3;
         default: high_zeros = 3'd0;
      endcase
   endfunction : high_zeros

   // single dword span or whole dwords minus edge gaps
   always_comb begin
      if (i_last_byte_enables == 4'h0) begin
         if (i_first_byte_enables == 4'h0) begin
            o_byte_count = 13'd1;
         end else begin
            o_byte_count = 13'd4 - {10'd0, low_zeros(i_first_byte_enables)}
                           - {10'd0, high_zeros(i_first_byte_enables)};
         end
      end else begin
         o_byte_count = {i_dword_count, 2'b00} - {10'd0, low_zeros(i_first_byte_enables)}
                        - {10'd0, high_zeros(i_last_byte_enables)};
      end
   end

endmodule : ccp_byte_count

`default_nettype wire

// >>> hdl/ccp_dword_src.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// picks the source of one dword position of the packet
module ccp_dword_src (
   input wire ccp_pkg::ccp_pos_t i_pos,
   input wire ccp_pkg::ccp_pos_t i_start,
   input wire ccp_pkg::ccp_pos_t i_end,
   input wire logic i_err,
   output ccp_pkg::ccp_src_e o_src,
   output ccp_pkg::ccp_pos_t o_off
);
   import ccp_pkg::*;

   // descriptor, then error words or padded payload
   always_comb begin
      o_src = CCP_SRC_ZERO;
      o_off = 12'd0;
      if (i_pos < `CCP_DESC_DW) begin
         o_src = CCP_SRC_DESC;
         o_off = i_pos;
      end else if (i_err) begin
         if (i_pos == `CCP_ERR_INFO_POS) begin
            o_src = CCP_SRC_INFO;
         end else if (i_pos < `CCP_ERR_PKT_DW) begin
            o_src = CCP_SRC_REQ;
            o_off = i_pos - `CCP_ERR_REQ_POS;
         end
      end else if (i_pos >= i_start && i_pos < i_end) begin
         o_src = CCP_SRC_PAY;
         o_off = i_pos - i_start;
      end
   end

endmodule : ccp_dword_src

`default_nettype wire

// >>> tb/ccp_dev_model.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// device side of the completion port: takes beats, flags nullify
module ccp_dev_model #(
   parameter int DATA_W = 64,
   parameter int SB_W = 33
) (
   input wire logic i_ref_clk,
   input wire logic i_reset_n,
   input wire logic [DATA_W-1:0] i_data,
   input wire logic i_valid,
   input wire logic i_last,
   input wire logic [SB_W-1:0] i_sideband,
   input wire logic i_slow,
   output logic o_ready
);
   localparam int L = DATA_W / 32;
   logic [31:0] pkt [0:15];
   int beats;
   int pkts;
   int internal_err;
   logic in_pkt;
   logic nulled;
   logic nul_now;
   logic digest;

   // digest appended when the descriptor forces it
   assign digest = pkt[2][31];

   // beat intake, packed dwords in order, sticky error tracking
   always @(posedge i_ref_clk) begin
      if (!i_reset_n) begin
         o_ready <= 1'b0;
         in_pkt <= 1'b0;
         nulled <= 1'b0;
         beats <= 0;
         pkts <= 0;
         internal_err <= 0;
      end else begin
         o_ready <= i_slow ? ~o_ready : 1'b1; // stalls every other cycle when slow
         if (in_pkt && !i_valid) nulled <= 1'b1;
         if (i_valid && o_ready) begin
            nul_now = (in_pkt & nulled) | i_sideband[0];
            for (int j = 0; j < L; j++) begin
               pkt[((in_pkt ? beats : 0) * L + j) % 16] <= i_data[j*32+:32];
            end
            beats <= in_pkt ? beats + 1 : 1;
            nulled <= nul_now;
            in_pkt <= !i_last;
            if (i_last) pkts <= pkts + 1;
            if (i_last && nul_now) internal_err <= internal_err + 1;
         end
      end
   end
endmodule : ccp_dev_model

`default_nettype wire

// >>> tb/ccp_checker.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// port checker of the completion controller
module ccp_checker #(
   parameter int DATA_W = 64,
   parameter int SB_W = 33
) (
   input wire logic i_ref_clk,
   input wire logic i_reset_n,
   input wire ccp_pkg::ccp_apb_req_s i_apb,
   input wire logic o_pready,
   input wire logic [31:0] o_prdata,
   input wire logic o_pslverr,
   input wire logic [DATA_W-1:0] o_cc_data,
   input wire logic o_cc_valid,
   input wire logic o_cc_last,
   input wire logic [SB_W-1:0] o_cc_sideband,
   input wire logic i_cc_ready
);
   import ccp_pkg::*;
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_reset_n);

   // ==========================================================
   // sequences
   sequence s_access;
      i_apb.psel && i_apb.penable;
   endsequence
   sequence s_start;
      s_access ##0 (i_apb.pwrite && i_apb.paddr == 8'h00 && i_apb.pwdata[0] && !o_cc_valid);
   endsequence
   sequence s_stall;
      o_cc_valid && !i_cc_ready;
   endsequence
   sequence s_end;
      o_cc_valid && i_cc_ready && o_cc_last;
   endsequence

   // ==========================================================
   // properties
   property p_hold;
      s_stall |=> o_cc_valid && $stable(o_cc_data) && $stable(o_cc_last);
   endproperty
   property p_no_gap;
      o_cc_valid && !(i_cc_ready && o_cc_last) |=> o_cc_valid;
   endproperty
   property p_end;
      s_end |=> !o_cc_valid;
   endproperty
   property p_disc_valid;
      o_cc_sideband[0] |-> o_cc_valid;
   endproperty
   property p_disc_hold;
      s_stall ##0 o_cc_sideband[0] |=> o_cc_sideband[0];
   endproperty
   property p_start;
      s_start |-> ##1 !o_cc_valid ##1 o_cc_valid;
   endproperty
   property p_unmapped;
      s_access ##0 (i_apb.paddr[1:0] != 2'h0 || i_apb.paddr > 8'h34) |-> o_pslverr && o_pready;
   endproperty
   property p_first_beat;
      (DATA_W == 64) && $rose(o_cc_valid) && !o_cc_sideband[0] |-> !o_cc_last;
   endproperty
   property p_sb_zero;
      o_cc_sideband[SB_W-1:1] == '0;
   endproperty

   a_hold: assert property (p_hold) else $error("stream changed while stalled");
   a_no_gap: assert property (p_no_gap) else $error("valid dropped inside packet");
   a_end: assert property (p_end) else $error("valid stayed after last beat");
   a_disc_valid: assert property (p_disc_valid) else $error("discontinue without valid");
   a_disc_hold: assert property (p_disc_hold) else $error("discontinue released while stalled");
   a_start: assert property (p_start) else $error("packet start latency wrong");
   a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
   a_first_beat: assert property (p_first_beat) else $error("descriptor beat marked last");
   a_sb_zero: assert property (p_sb_zero) else $error("unused sideband bits set");
endmodule : ccp_checker

bind ccp_completion_host ccp_checker #(.DATA_W(DATA_W), .SB_W(SB_W)) i_chk (
   .i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_apb(i_apb), .o_pready(o_pready),
   .o_prdata(o_prdata), .o_pslverr(o_pslverr), .o_cc_data(o_cc_data), .o_cc_valid(o_cc_valid),
   .o_cc_last(o_cc_last), .o_cc_sideband(o_cc_sideband), .i_cc_ready(i_cc_ready));

`default_nettype wire

// >>> tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "ccp_cfg.svh"
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin \
   $display("[ERR] %s exp %h got %h", nm, ex, got); bad_count++; end end

// ==========================================================
// bench top
module tb;
   import ccp_pkg::*;
   localparam int DATA_W = 64;
   localparam int SB_W = 33;
   logic i_ref_clk = 1'b0;
   logic i_reset_n = 1'b0;
   ccp_apb_req_s apb = '0;
   logic slow = 1'b0;
   logic o_pready, o_pslverr, o_cc_valid, o_cc_last, ready;
   logic [31:0] o_prdata, rdat;
   logic rerr;
   logic [DATA_W-1:0] o_cc_data;
   logic [SB_W-1:0] o_cc_sideband;
   int bad_count = 0;
   int compares = 0;

   ccp_completion_host #(.DATA_W(DATA_W), .SB_W(SB_W), .PAY_DEPTH(64)) i_dut (
      .i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_apb(apb), .o_pready(o_pready),
      .o_prdata(o_prdata), .o_pslverr(o_pslverr), .o_cc_data(o_cc_data), .o_cc_valid(o_cc_valid),
      .o_cc_last(o_cc_last), .o_cc_sideband(o_cc_sideband), .i_cc_ready(ready));
   ccp_dev_model #(.DATA_W(DATA_W), .SB_W(SB_W)) i_dev (
      .i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_data(o_cc_data), .i_valid(o_cc_valid),
      .i_last(o_cc_last), .i_sideband(o_cc_sideband), .i_slow(slow), .o_ready(ready));

   // clock
   initial begin
      forever #5 i_ref_clk = ~i_ref_clk;
   end

   // ==========================================================
   // bus and report tasks
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : stop_test

   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge i_ref_clk);
      apb <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
      @(posedge i_ref_clk);
      apb.penable <= 1'b1;
      @(posedge i_ref_clk);
      while (o_pready !== 1'b1) begin
         @(posedge i_ref_clk);
      end
      rdat = o_prdata;
      rerr = o_pslverr;
      apb <= '0;
   endtask : xfer

   task automatic go(input logic [31:0] ctrl);
      int p;
      p = i_dev.pkts;
      xfer(1'b1, `CCP_ADDR_CTRL, ctrl | 32'h1);
      repeat (3) @(posedge i_ref_clk);
      do begin
         xfer(1'b0, `CCP_ADDR_STATUS, 32'h0);
      end while (rdat[0] !== 1'b0);
      `CHK("packets", p + 1, i_dev.pkts);
   endtask : go

   task automatic load(input logic [31:0] d0, input logic [31:0] d1, input logic [31:0] info, input int np);
      xfer(1'b1, `CCP_ADDR_DESC0, d0);
      xfer(1'b1, `CCP_ADDR_DESC1, d1);
      xfer(1'b1, `CCP_ADDR_DESC2, 32'h0000_1234);
      xfer(1'b1, `CCP_ADDR_REQ_INFO, info);
      xfer(1'b1, `CCP_ADDR_PAY_IDX, 32'h0);
      for (int i = 0; i < np; i++) xfer(1'b1, `CCP_ADDR_PAY_DATA, 32'ha5a5_0000 + i);
   endtask : load

   // ==========================================================
   // scenarios
   task automatic t_regs;
      xfer(1'b0, `CCP_ADDR_CTRL, 32'h0);
      `CHK("ctrl reset", `CCP_CTRL_RESET, rdat);
      xfer(1'b0, 8'h38, 32'h0);
      `CHK("unmapped err", 1'b1, rerr);
      xfer(1'b1, 8'h02, 32'h0);
      `CHK("misaligned err", 1'b1, rerr);
   endtask : t_regs

   task automatic t_bcount;
      logic [3:0] fb [6] = '{4'h9, 4'h6, 4'h0, 4'h1, 4'h4, 4'h8};
      logic [3:0] lb [6] = '{4'h0, 4'h0, 4'h0, 4'h8, 4'h1, 4'h2};
      logic [10:0] dc [6] = '{11'h1, 11'h1, 11'h1, 11'h2, 11'h3, 11'h2};
      logic [12:0] ex [6] = '{13'h4, 13'h2, 13'h1, 13'h8, 13'h7, 13'h3};
      for (int i = 0; i < 6; i++) begin
         xfer(1'b1, `CCP_ADDR_REQ_INFO, {24'h0, lb[i], fb[i]});
         xfer(1'b1, `CCP_ADDR_DESC1, {21'h0, dc[i]});
         xfer(1'b0, `CCP_ADDR_BCOUNT, 32'h0);
         `CHK("byte count", ex[i], rdat[12:0]);
      end
   endtask : t_bcount

   task automatic t_dword;
      slow <= 1'b1;
      load(32'h0000_0008, 32'h2, 32'hff, 2);
      go(32'h0000_0168);
      `CHK("desc0", 32'h0008_0008, i_dev.pkt[0]);
      `CHK("desc2", 32'hd000_1234, i_dev.pkt[2]);
      `CHK("digest", 1'b1, i_dev.digest);
      `CHK("pay0", 32'ha5a5_0000, i_dev.pkt[3]);
      `CHK("pay1", 32'ha5a5_0001, i_dev.pkt[4]);
      `CHK("beats", 3, i_dev.beats);
      `CHK("nulled", 1'b0, i_dev.nulled);
      slow <= 1'b0;
   endtask : t_dword

   task automatic t_addr;
      for (int m = 0; m < 2; m++) begin
         load(32'h0000_0004, 32'h2, 32'hff, 2);
         go(32'h0000_0022 | (m << 4));
         `CHK("desc", 32'h0008_0004, i_dev.pkt[0]);
         `CHK("pad", 32'h0, i_dev.pkt[3]);
         `CHK("lane", 32'ha5a5_0000, i_dev.pkt[m ? 5 : 4]);
         `CHK("beats", m ? 4 : 3, i_dev.beats);
      end
   endtask : t_addr

   task automatic t_err;
      for (int m = 0; m < 2; m++) begin
         load(32'h0000_0008, 32'h1, 32'h0005_5a3c, 0);
         for (int k = 0; k < 4; k++) xfer(1'b1, `CCP_ADDR_REQ0 + 8'(4 * k), 32'hc0de_0000 + k);
         go(32'h0000_0004 | (m << 1));
         `CHK("info", 32'h0005_5a3c, i_dev.pkt[3]);
         for (int k = 0; k < 4; k++) `CHK("req", 32'hc0de_0000 + k, i_dev.pkt[4 + k]);
         `CHK("beats", 4, i_dev.beats);
      end
   endtask : t_err

   task automatic t_disc;
      int e;
      for (int early = 0; early < 2; early++) begin
         e = i_dev.internal_err;
         load(32'h0000_0008, 32'h4, 32'hff, 4);
         xfer(1'b1, `CCP_ADDR_DISC, 32'h0000_0101 | (early << 9));
         go(32'h0000_0020);
         `CHK("nulled", 1'b1, i_dev.nulled);
         `CHK("beats", early ? 2 : 4, i_dev.beats);
         `CHK("internal err", e + 1, i_dev.internal_err);
         `CHK("aborted", 1'b1, rdat[1]);
         xfer(1'b1, `CCP_ADDR_DISC, 32'h0);
      end
   endtask : t_disc

   // main sequence
   initial begin
      repeat (12) @(posedge i_ref_clk);
      i_reset_n <= 1'b1;
      @(posedge i_ref_clk);
      t_regs();
      t_bcount();
      t_dword();
      t_addr();
      t_err();
      t_disc();
      stop_test();
   end

   // hang guard
   initial begin
      repeat (30000) @(posedge i_ref_clk);
      bad_count++;
      stop_test();
   end
endmodule : tb

`default_nettype wire
